// ### design/pslc_map.svh
/*
  pslc_map.svh - strap positions, led mode codes and reset values for the
  port strap link configuration block.
  assumes: included by bare name from the package and the design module.
*/
`ifndef PSLC_MAP_SVH
`define PSLC_MAP_SVH

// strap vector bit positions
`define PSLC_IDX_P1_DPX 0
`define PSLC_IDX_P2_ANEN 1
`define PSLC_IDX_P2_SPD 2
`define PSLC_IDX_P2_DPX 3
`define PSLC_IDX_P2_FFC 4
`define PSLC_IDX_P1_FFC 5
`define PSLC_IDX_P1_SPD 6
`define PSLC_IDX_P1_ANEN 7
`define PSLC_STRAP_W 8

// fill count that ends the reset phase; three edges fill the pad synchroniser before straps are compared
`define PSLC_SYNC_FILL 2'h2

// led mode select field, bits [5:4] of the led config register
`define PSLC_LED_MODE_LSB 4
`define PSLC_LED_MODE_MSB 5
`define PSLC_LED_MODE_DEFAULT 2'h0

// reset value of the strap capture: the internal pull levels
// (pull-up on all but port-1 autoneg and port-1 flow control)
`define PSLC_STRAP_RESET 8'h5f

`endif

// ### design/pslc_pkg.sv
/*
  pslc_pkg.sv - types of the port strap link configuration block.
  assumes: pslc_map.svh on the include path.
*/
`include "pslc_map.svh"

package pslc_pkg;

  typedef enum logic [1:0] {
    PSLC_RESET = 2'b00,
    PSLC_SAMPLE = 2'b01,
    PSLC_RUN = 2'b10
  } pslc_phase_e;

  typedef logic [`PSLC_STRAP_W-1:0] pslc_strap_t;

  typedef struct packed {
    logic autoneg_en;
    logic speed_100;
    logic duplex_full;
    logic flowctl_force;
  } pslc_port_cfg_s;

  typedef struct packed {
    pslc_phase_e phase;
    logic [1:0] fill;
    pslc_strap_t sync1;
    pslc_strap_t sync2;
    pslc_strap_t sync3;
    pslc_strap_t latched;
    logic [4:0] p3_rx;
    logic [1:0] led_p1;
  } pslc_state_s;

endpackage : pslc_pkg

// ### design/pslc_port_strap_link_config.sv
/*
  pslc_port_strap_link_config.sv - strap capture and port link defaults for
  the two copper ports, plus the strap pins' normal output use afterwards.
  assumes: one 25 MHz clock, asynchronous active-high reset, pins arrive
  through input buffers as levels; pad drivers honour the *_oe outputs.
*/
// How it works
// - port-1 duplex strap high: full duplex fallback or forced full duplex
// - port-1 duplex strap low: half duplex fallback or forced half duplex
// - port-2 autoneg strap high enables autoneg, low disables it
// - port-2 speed strap forces 100BT high, 10BT low, when autoneg off
// - port-2 duplex strap high: full duplex fallback or forced full duplex
// - port-2 duplex strap low: half duplex fallback or forced half duplex
// - port-2 flow-control strap high forces flow control, low follows autoneg
// - port-1 flow-control strap high forces flow control, low follows autoneg
// - port-1 speed strap forces 100BT high, 10BT low, when autoneg off
// - port-1 autoneg strap high enables, low disables; pull-down default off
// - port-1 led pins show speed and link/activity in mode 0, mode from bits [5:4]
// - after sampling, port-3 strap pins drive rx valid and rx data
`include "pslc_map.svh"

module pslc_port_strap_link_config (
  input wire logic clk,
  input wire logic rst,
  // strap pin levels as seen at the pads
  input wire logic port1_duplex_strap,
  input wire logic port2_autoneg_strap,
  input wire logic port2_speed_strap,
  input wire logic port2_duplex_strap,
  input wire logic port2_force_flowctl_strap,
  input wire logic port1_force_flowctl_strap,
  input wire logic port1_speed_strap,
  input wire logic port1_autoneg_strap,
  // autoneg outcome from each port's phy
  input wire logic p1_an_done,
  input wire logic p1_an_ok,
  input wire logic p1_an_speed_100,
  input wire logic p1_an_full,
  input wire logic p1_an_pause,
  input wire logic p2_an_done,
  input wire logic p2_an_ok,
  input wire logic p2_an_speed_100,
  input wire logic p2_an_full,
  input wire logic p2_an_pause,
  // switch port-3 receive side and led sources
  input wire logic sw_rx_valid,
  input wire logic [3:0] sw_rx_data,
  input wire logic [1:0] led_mode_sel,
  input wire logic p1_link,
  input wire logic p1_activity,
  // pin drive
  output logic p3_rx_valid_out,
  output logic p3_rx_bit3_out,
  output logic p3_rx_bit2_out,
  output logic p3_rx_bit1_out,
  output logic p3_rx_bit0_out,
  output logic p3_rx_oe,
  output logic port1_indicator_a,
  output logic port1_indicator_b,
  output logic port1_indicator_oe,
  // resolved port settings
  output pslc_pkg::pslc_port_cfg_s p1_cfg_default,
  output pslc_pkg::pslc_port_cfg_s p2_cfg_default,
  output pslc_pkg::pslc_port_cfg_s p1_link_mode,
  output pslc_pkg::pslc_port_cfg_s p2_link_mode,
  output logic straps_valid
);

  ////////////////////////////////////////////////////////////////////////////

  pslc_pkg::pslc_state_s st;
  pslc_pkg::pslc_state_s next_st;
  pslc_pkg::pslc_strap_t pins;

  // resolve one port's live mode from its strap defaults and autoneg result
  function automatic pslc_pkg::pslc_port_cfg_s resolve(
    input pslc_pkg::pslc_port_cfg_s dflt,
    input logic done,
    input logic ok,
    input logic spd,
    input logic full,
    input logic pause
  );
    pslc_pkg::pslc_port_cfg_s r;
    r = dflt;
    if (dflt.autoneg_en && done && ok) begin
      r.speed_100 = spd;
      r.duplex_full = full;
      r.flowctl_force = dflt.flowctl_force | pause;
    end else if (dflt.autoneg_en) begin
      // failed or pending autoneg keeps the strapped duplex fallback
      r.flowctl_force = dflt.flowctl_force;
    end
    return r;
  endfunction : resolve

  ////////////////////////////////////////////////////////////////////////////

  // indicator pair {b, a}; modes 1 to 3 are local choices, mode 0 the default
  function automatic logic [1:0] led_pair(
    input logic [1:0] mode,
    input pslc_pkg::pslc_port_cfg_s cfg,
    input logic link,
    input logic act
  );
    logic [1:0] r;
    case (mode)
      2'h0: r = {cfg.speed_100, link & ~act};
      2'h1: r = {cfg.duplex_full, link};
      2'h2: r = {cfg.duplex_full, link & ~act};
      default: r = {cfg.speed_100, link};
    endcase
    return r;
  endfunction : led_pair

  assign pins[`PSLC_IDX_P1_DPX] = port1_duplex_strap;
  assign pins[`PSLC_IDX_P2_ANEN] = port2_autoneg_strap;
  assign pins[`PSLC_IDX_P2_SPD] = port2_speed_strap;
  assign pins[`PSLC_IDX_P2_DPX] = port2_duplex_strap;
  assign pins[`PSLC_IDX_P2_FFC] = port2_force_flowctl_strap;
  assign pins[`PSLC_IDX_P1_FFC] = port1_force_flowctl_strap;
  assign pins[`PSLC_IDX_P1_SPD] = port1_speed_strap;
  assign pins[`PSLC_IDX_P1_ANEN] = port1_autoneg_strap;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st = st;
    // three-stage sync; reset value holds the pull levels
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    case (st.phase)
      pslc_pkg::PSLC_RESET: begin
        // sync stages reset to the pull levels; comparing before they hold
        // real pad samples would latch those instead of the board straps
        if (st.fill == `PSLC_SYNC_FILL) begin
          next_st.phase = pslc_pkg::PSLC_SAMPLE;
        end else begin
          next_st.fill = st.fill + 2'h1;
        end
      end
      pslc_pkg::PSLC_SAMPLE: begin
        // capture only once stages agree; board holds levels steady
        if (st.sync2 == st.sync3) begin
          next_st.latched = st.sync3;
          next_st.phase = pslc_pkg::PSLC_RUN;
        end
      end
      pslc_pkg::PSLC_RUN: begin
        next_st.latched = st.latched;
      end
      default: begin
        next_st.phase = pslc_pkg::PSLC_RESET;
        next_st.fill = 2'h0;
      end
    endcase
    if (st.phase == pslc_pkg::PSLC_RUN) begin
      next_st.p3_rx = {sw_rx_valid, sw_rx_data};
      next_st.led_p1 = led_pair(led_mode_sel, p1_link_mode, p1_link, p1_activity);
    end else begin
      next_st.p3_rx = 5'h00;
      next_st.led_p1 = 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.phase <= pslc_pkg::PSLC_RESET;
      st.fill <= 2'h0;
      st.sync1 <= `PSLC_STRAP_RESET;
      st.sync2 <= `PSLC_STRAP_RESET;
      st.sync3 <= `PSLC_STRAP_RESET;
      st.latched <= `PSLC_STRAP_RESET;
      st.p3_rx <= 5'h00;
      st.led_p1 <= 2'h0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    p1_cfg_default.autoneg_en = st.latched[`PSLC_IDX_P1_ANEN];
    p1_cfg_default.speed_100 = st.latched[`PSLC_IDX_P1_SPD];
    p1_cfg_default.duplex_full = st.latched[`PSLC_IDX_P1_DPX];
    p1_cfg_default.flowctl_force = st.latched[`PSLC_IDX_P1_FFC];
    p2_cfg_default.autoneg_en = st.latched[`PSLC_IDX_P2_ANEN];
    p2_cfg_default.speed_100 = st.latched[`PSLC_IDX_P2_SPD];
    p2_cfg_default.duplex_full = st.latched[`PSLC_IDX_P2_DPX];
    p2_cfg_default.flowctl_force = st.latched[`PSLC_IDX_P2_FFC];
  end

  // strap bits pass through when autoneg is off, failed or pending; autoneg result once done and ok
  assign p1_link_mode = resolve(
    p1_cfg_default,
    p1_an_done,
    p1_an_ok,
    p1_an_speed_100,
    p1_an_full,
    p1_an_pause
  );
  assign p2_link_mode = resolve(
    p2_cfg_default,
    p2_an_done,
    p2_an_ok,
    p2_an_speed_100,
    p2_an_full,
    p2_an_pause
  );

  assign straps_valid = (st.phase == pslc_pkg::PSLC_RUN);

  // pins stay undriven while sampling so board pulls are read, not fought
  assign p3_rx_oe = straps_valid;
  assign port1_indicator_oe = straps_valid;
  // data pins straight from flops so no decode glitch reaches the pads
  always_comb begin
    p3_rx_valid_out = st.p3_rx[4];
    p3_rx_bit3_out = st.p3_rx[3];
    p3_rx_bit2_out = st.p3_rx[2];
    p3_rx_bit1_out = st.p3_rx[1];
    p3_rx_bit0_out = st.p3_rx[0];
    port1_indicator_b = st.led_p1[1];
    port1_indicator_a = st.led_p1[0];
  end

endmodule : pslc_port_strap_link_config

// ### verification/pslc_board.sv
/* pslc_board.sv: board resistors on the eight strap pins.
   assumes: en low leaves only the device's internal pulls. */
module pslc_board (
  input wire logic en,
  input wire logic [7:0] lev,
  output logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels stay put through reset; internal pulls down on p1 autoneg, p1 flow
  assign pins = en ? lev : 8'h5f;
endmodule : pslc_board

// ### verification/pslc_checker.sv
/* pslc_checker.sv: port assertions for the strap config block.
   assumes: bound below; straps steady from reset until latched. */
module pslc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic straps_valid,
  input wire logic p3_rx_oe,
  input wire logic port1_indicator_oe,
  input wire logic port1_duplex_strap,
  input wire logic port2_autoneg_strap,
  input wire logic port2_speed_strap,
  input wire logic port2_duplex_strap,
  input wire logic port2_force_flowctl_strap,
  input wire logic port1_speed_strap,
  input wire logic port1_force_flowctl_strap,
  input wire logic port1_autoneg_strap,
  input wire logic sw_rx_valid,
  input wire logic [3:0] sw_rx_data,
  input wire logic p3_rx_valid_out,
  input wire logic p3_rx_bit3_out,
  input wire logic p3_rx_bit2_out,
  input wire logic p3_rx_bit1_out,
  input wire logic p3_rx_bit0_out,
  input wire pslc_pkg::pslc_port_cfg_s p1_cfg_default,
  input wire pslc_pkg::pslc_port_cfg_s p2_cfg_default,
  input wire pslc_pkg::pslc_port_cfg_s p1_link_mode,
  input wire pslc_pkg::pslc_port_cfg_s p2_link_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_latch; !straps_valid ##1 straps_valid; endsequence
  // pads may move once latched, so compare with the levels at the latch edge
  property p_p1_cap; s_latch |-> p1_cfg_default == {$past(port1_autoneg_strap),
    $past(port1_speed_strap), $past(port1_duplex_strap),
    $past(port1_force_flowctl_strap)}; endproperty
  a_p1_cap: assert property (p_p1_cap) else $error("p1 capture");
  property p_p2_cap; s_latch |-> p2_cfg_default == {$past(port2_autoneg_strap),
    $past(port2_speed_strap), $past(port2_duplex_strap),
    $past(port2_force_flowctl_strap)}; endproperty
  a_p2_cap: assert property (p_p2_cap) else $error("p2 capture");
  // steady pins must latch within a few edges of release
  property p_soon; !straps_valid |-> ##[1:5] straps_valid; endproperty
  a_soon: assert property (p_soon) else $error("no latch");
  property p_hold; straps_valid |=> straps_valid && $stable(p1_cfg_default)
    && $stable(p2_cfg_default); endproperty
  a_hold: assert property (p_hold) else $error("cfg moved");
  property p_p1_frc; straps_valid && !p1_cfg_default.autoneg_en |->
    p1_link_mode[2:1] == p1_cfg_default[2:1]; endproperty
  a_p1_frc: assert property (p_p1_frc) else $error("p1 forced");
  property p_p2_frc; straps_valid && !p2_cfg_default.autoneg_en |->
    p2_link_mode[2:1] == p2_cfg_default[2:1]; endproperty
  a_p2_frc: assert property (p_p2_frc) else $error("p2 forced");
  property p_fc; straps_valid |-> (p1_link_mode[0] || !p1_cfg_default[0])
    && (p2_link_mode[0] || !p2_cfg_default[0]); endproperty
  a_fc: assert property (p_fc) else $error("flow force");
  property p_oe; p3_rx_oe == straps_valid && port1_indicator_oe == straps_valid; endproperty
  a_oe: assert property (p_oe) else $error("pin drive");
  // port-3 pins repeat the switch receive side one clock late once running
  property p_rx; $past(straps_valid) |-> {p3_rx_valid_out, p3_rx_bit3_out, p3_rx_bit2_out,
    p3_rx_bit1_out, p3_rx_bit0_out} == {$past(sw_rx_valid), $past(sw_rx_data)}; endproperty
  a_rx: assert property (p_rx) else $error("rx pins");
endmodule : pslc_checker
bind pslc_port_strap_link_config pslc_checker i_chk (
  .clk(clk),
  .rst(rst),
  .straps_valid(straps_valid),
  .p3_rx_oe(p3_rx_oe),
  .port1_indicator_oe(port1_indicator_oe),
  .port1_duplex_strap(port1_duplex_strap),
  .port2_autoneg_strap(port2_autoneg_strap),
  .port2_speed_strap(port2_speed_strap),
  .port2_duplex_strap(port2_duplex_strap),
  .port2_force_flowctl_strap(port2_force_flowctl_strap),
  .port1_speed_strap(port1_speed_strap),
  .port1_force_flowctl_strap(port1_force_flowctl_strap),
  .port1_autoneg_strap(port1_autoneg_strap),
  .sw_rx_valid(sw_rx_valid),
  .sw_rx_data(sw_rx_data),
  .p3_rx_valid_out(p3_rx_valid_out),
  .p3_rx_bit3_out(p3_rx_bit3_out),
  .p3_rx_bit2_out(p3_rx_bit2_out),
  .p3_rx_bit1_out(p3_rx_bit1_out),
  .p3_rx_bit0_out(p3_rx_bit0_out),
  .p1_cfg_default(p1_cfg_default),
  .p2_cfg_default(p2_cfg_default),
  .p1_link_mode(p1_link_mode),
  .p2_link_mode(p2_link_mode)
);

// ### verification/tb_top.sv
/* tb_top.sv: self-checking bench for the strap config block.
   assumes: pslc_board stands in for the board's strap resistors. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, en, sv, oe, ioe;
  logic [7:0] lev;
  logic [4:0] an, rx;
  logic [1:0] lm, la;
  wire [7:0] pins;
  wire [4:0] ro;
  wire [1:0] ld;
  pslc_pkg::pslc_port_cfg_s c1, c2, m1, m2;
  logic [7:0] pat[4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
  int miscompares = 0;
  int n_tests = 0;
  pslc_board i_brd (.en(en), .lev(lev), .pins(pins));
  pslc_port_strap_link_config i_dut (.clk(clk), .rst(rst),
    .port1_duplex_strap(pins[0]), .port2_autoneg_strap(pins[1]),
    .port2_speed_strap(pins[2]), .port2_duplex_strap(pins[3]),
    .port2_force_flowctl_strap(pins[4]), .port1_force_flowctl_strap(pins[5]),
    .port1_speed_strap(pins[6]), .port1_autoneg_strap(pins[7]),
    .p1_an_done(an[4]), .p1_an_ok(an[3]), .p1_an_speed_100(an[2]),
    .p1_an_full(an[1]), .p1_an_pause(an[0]), .p2_an_done(an[4]), .p2_an_ok(an[3]),
    .p2_an_speed_100(an[2]), .p2_an_full(an[1]), .p2_an_pause(an[0]),
    .sw_rx_valid(rx[4]), .sw_rx_data(rx[3:0]), .led_mode_sel(lm),
    .p1_link(la[1]), .p1_activity(la[0]), .p3_rx_valid_out(ro[4]),
    .p3_rx_bit3_out(ro[3]), .p3_rx_bit2_out(ro[2]), .p3_rx_bit1_out(ro[1]),
    .p3_rx_bit0_out(ro[0]), .p3_rx_oe(oe), .port1_indicator_a(ld[0]),
    .port1_indicator_b(ld[1]), .port1_indicator_oe(ioe), .p1_cfg_default(c1),
    .p2_cfg_default(c2), .p1_link_mode(m1), .p2_link_mode(m2), .straps_valid(sv));
////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic chk(string nm, logic [4:0] got, logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // pins set before reset so they stand the whole time
  task automatic boot(logic e, logic [7:0] v);
    int k = 0;
    en = e;
    lev = v;
    rst = 1;
    repeat (5) @(posedge clk);
    #1 chk("oe_rst", {3'h0, oe, ioe}, 5'h00);
    chk("rx_rst", ro, 5'h00);
    chk("led_rst", {3'h0, ld}, 5'h00);
    rst = 0;
    while (sv !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1 k++;
    end
    chk("latched", {4'h0, sv}, 5'h01);
  endtask : boot
////////////////////////////////////////////////////////////////////////
  // autoneg idle, so link mode must equal the straps
  task automatic t_straps(logic e, logic [7:0] v);
    boot(e, v);
    chk("p1_cfg", {1'b0, c1}, {1'b0, v[7], v[6], v[0], v[5]});
    chk("p2_cfg", {1'b0, c2}, {1'b0, v[1], v[2], v[3], v[4]});
    chk("p1_mode", {1'b0, m1}, {1'b0, v[7], v[6], v[0], v[5]});
    chk("p2_mode", {1'b0, m2}, {1'b0, v[1], v[2], v[3], v[4]});
    lev = ~v;
    repeat (4) @(posedge clk);
    #1 chk("p1_hold", {1'b0, c1}, {1'b0, v[7], v[6], v[0], v[5]});
  endtask : t_straps
  task automatic t_an();
    boot(1'b1, 8'hcf);
    an = 5'h19;
    @(posedge clk);
    #1 chk("p1_an_ok", {1'b0, m1}, 5'h09);
    chk("p2_an_ok", {1'b0, m2}, 5'h09);
    an = 5'h11;
    @(posedge clk);
    #1 chk("p1_an_bad", {1'b0, m1}, 5'h0e);
    chk("p2_an_bad", {1'b0, m2}, 5'h0e);
  endtask : t_an
  // duplex and flow straps low: failed autoneg gives half duplex, no flow control
  task automatic t_an_half();
    boot(1'b1, 8'h82);
    an = 5'h11;
    @(posedge clk);
    #1 chk("p1_an_half", {1'b0, m1}, 5'h08);
    chk("p2_an_half", {1'b0, m2}, 5'h08);
  endtask : t_an_half
  // rx path is one clock late; led mode 0 shows speed and link/activity
  task automatic t_io();
    an = 5'h1e;
    rx = 5'h1a;
    la = 2'h2;
    @(posedge clk);
    #1 chk("rx_out", ro, 5'h1a);
    chk("led", {3'h0, ld}, 5'h03);
    rx = 5'h05;
    la = 2'h3;
    @(posedge clk);
    #1 chk("rx_next", ro, 5'h05);
    chk("led_act", {3'h0, ld}, 5'h02);
    // speed up, duplex half so every mode shows a distinct pair
    an = 5'h1c;
    lm = 2'h1;
    @(posedge clk);
    #1 chk("led_m1", {3'h0, ld}, 5'h01);
    lm = 2'h2;
    @(posedge clk);
    #1 chk("led_m2", {3'h0, ld}, 5'h00);
    lm = 2'h3;
    @(posedge clk);
    #1 chk("led_m3", {3'h0, ld}, 5'h03);
  endtask : t_io
  initial begin
    rx = 5'h00;
    lm = 2'h0;
    la = 2'h0;
    an = 5'h00;
    foreach (pat[i]) t_straps(1'b1, pat[i]);
    t_straps(1'b0, 8'h5f);
    t_an();
    t_an_half();
    t_io();
    finish_test();
  end
  // whole run is about a hundred clocks
  initial begin
    #(2000 * 40);
    miscompares++;
    finish_test();
  end
endmodule : tb_top
